// >>> design/cco_pkg.sv
// shared constants and types for the charger option one control block
package cco_pkg;

  // ----------------------------------------------------------------------
  // register addresses and power-on value
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_LOW = 8'h30;
  localparam logic [7:0] ADDR_HIGH = 8'h31;
  localparam logic [15:0] RESET_VALUE = 16'h0211;

  // ----------------------------------------------------------------------
  // field positions in the 16-bit word, high byte at [15:8]
  // ----------------------------------------------------------------------
  localparam int BIT_BATT_MON = 15;
  localparam int BIT_LPHOT_HI = 14;
  localparam int BIT_LPHOT_LO = 13;
  localparam int BIT_SYS_PWR = 12;
  localparam int BIT_IN_RES = 11;
  localparam int BIT_CHG_RES = 10;
  localparam int BIT_GAIN = 9;
  localparam int BIT_PIN_SEL = 8;
  localparam int BIT_REF_SEL = 7;
  localparam int BIT_POLARITY = 6;
  localparam int BIT_DEG_HI = 5;
  localparam int BIT_DEG_LO = 4;
  localparam int BIT_SHUTOFF = 3;
  localparam int BIT_PASS = 2;
  localparam int BIT_SHIP = 1;
  localparam int BIT_WAKE = 0;

  // ----------------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] LPHOT_OFF = 2'h0;
  localparam logic [1:0] LPHOT_SYS = 2'h1;
  localparam logic [1:0] DEG_OFF = 2'h0;
  localparam logic [1:0] DEG_1US = 2'h1;
  localparam logic [1:0] DEG_2MS = 2'h2;
  localparam logic [1:0] DEG_5S = 2'h3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd50_000_000;
  localparam longint unsigned CLK_PERIOD_NS = 64'd20;
  localparam longint unsigned DEG_1US_NS = 64'd1000;
  localparam longint unsigned DEG_2MS_US = 64'd2000;
  localparam longint unsigned DEG_5S_S = 64'd5;
  localparam longint unsigned SHIP_MS = 64'd140;
  localparam longint unsigned WAKE_MIN = 64'd30;
  // deglitch times are least times: round up
  localparam logic [27:0] DEG_1US_CYC =
    28'((DEG_1US_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);
  localparam logic [27:0] DEG_2MS_CYC =
    28'((DEG_2MS_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);
  localparam logic [27:0] DEG_5S_CYC = 28'(DEG_5S_S * CLK_HZ);
  // windows are longest times: round down
  localparam logic [22:0] SHIP_CYC = 23'(SHIP_MS * CLK_HZ / 64'd1000);
  localparam logic [36:0] WAKE_CYC = 37'(WAKE_MIN * 64'd60 * CLK_HZ);

  // ----------------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------------
  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [3:0] I2C_LAST = 4'h7;

  typedef enum logic [8:0] {
    CCO_IDLE = 9'h001,
    CCO_ADDR = 9'h002,
    CCO_ACK_A = 9'h004,
    CCO_PTR = 9'h008,
    CCO_ACK_P = 9'h010,
    CCO_WDAT = 9'h020,
    CCO_ACK_W = 9'h040,
    CCO_RD = 9'h080,
    CCO_RACK = 9'h100
  } cco_i2c_state_t;

endpackage

// >>> design/cco_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module cco_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> design/cco_fall_deglitch.sv
// falling-edge deglitch: high passes at once, low only after a held count
`timescale 1ns/1ns
`default_nettype none
module cco_fall_deglitch #(
  parameter int CW = 28
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic raw_in,
  input wire logic [CW-1:0] limit_in,
  output logic level_out
);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      level_out <= 1'b1;
    end else if (!enable_in || raw_in) begin
      cnt_q <= '0;
      level_out <= 1'b1;
    end else if (level_out) begin
      // limit of one means low is taken on the first low sample
      if (cnt_q >= limit_in - CW'(1)) begin
        level_out <= 1'b0;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule
`default_nettype wire

// >>> design/cco_option_one.sv
// charger option one register pair with its serial slave and timed actions
`timescale 1ns/1ns
`default_nettype none
module cco_option_one #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary slave address
  parameter logic [27:0] DEG_2MS_CYCLES = cco_pkg::DEG_2MS_CYC,
  parameter logic [27:0] DEG_5S_CYCLES = cco_pkg::DEG_5S_CYC,
  parameter logic [22:0] SHIP_CYCLES = cco_pkg::SHIP_CYC,
  parameter logic [36:0] WAKE_CYCLES = cco_pkg::WAKE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_out,
  input wire logic low_power_mode_in,
  input wire logic comparator_input_in,
  input wire logic batt_below_minsys_in,
  input wire logic current_limit_pin_in,
  input wire logic adapter_good_in,
  output logic batt_current_monitor_out,
  output logic system_power_monitor_out,
  output logic processor_hot_alert_lowpower_out,
  output logic input_resistor_select_out,
  output logic charge_resistor_select_out,
  output logic power_monitor_gain_out,
  output logic high_impedance_mode_out,
  output logic pass_through_mode_out,
  output logic comparator_reference_select_out,
  output logic comparator_output_out,
  output logic input_high_switch_off_out,
  output logic output_high_switch_off_out,
  output logic charger_good_out,
  output logic shipping_discharge_out,
  output logic wakeup_charge_out
);

  // ----------------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;
  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic above_s;
  logic batt_low_s;
  logic limit_pin_s;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  cco_sync #(.WIDTH(5)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .async_in({i2c_scl_in, i2c_sda_in, comparator_input_in,
               batt_below_minsys_in, current_limit_pin_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign above_s = pins_s[2];
  assign batt_low_s = pins_s[1];
  assign limit_pin_s = pins_s[0];

  // ----------------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------------
  cco_pkg::cco_i2c_state_t state_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] wr_ptr_q;
  logic [7:0] wr_data_q;
  logic wr_stb_q;
  logic rw_q;
  logic mack_q;
  logic [15:0] opt_q;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic wr_low;
  logic wr_high;

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign wr_low = wr_stb_q && (wr_ptr_q == cco_pkg::ADDR_LOW);
  assign wr_high = wr_stb_q && (wr_ptr_q == cco_pkg::ADDR_HIGH);

  // unmapped addresses read zero and swallow writes
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == cco_pkg::ADDR_LOW) begin
      rd_byte = opt_q[7:0];
    end else if (ptr_q == cco_pkg::ADDR_HIGH) begin
      rd_byte = opt_q[15:8];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cco_pkg::CCO_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      wr_ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_c) begin
        state_q <= cco_pkg::CCO_ADDR;
        cnt_q <= 4'h0;
      end else if (stop_c) begin
        state_q <= cco_pkg::CCO_IDLE;
      end else begin
        case (state_q)
          cco_pkg::CCO_ADDR, cco_pkg::CCO_PTR, cco_pkg::CCO_WDAT: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == cco_pkg::I2C_BITS) begin
              cnt_q <= 4'h0;
              if (state_q == cco_pkg::CCO_ADDR) begin
                if (shift_q[7:1] == DEV_ADDR) begin
                  rw_q <= shift_q[0];
                  state_q <= cco_pkg::CCO_ACK_A;
                end else begin
                  state_q <= cco_pkg::CCO_IDLE;
                end
              end else if (state_q == cco_pkg::CCO_PTR) begin
                ptr_q <= shift_q;
                state_q <= cco_pkg::CCO_ACK_P;
              end else begin
                wr_stb_q <= 1'b1;
                wr_ptr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                state_q <= cco_pkg::CCO_ACK_W;
              end
            end
          end
          cco_pkg::CCO_ACK_A: begin
            if (scl_fall) begin
              if (rw_q) begin
                shift_q <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h0;
                state_q <= cco_pkg::CCO_RD;
              end else begin
                state_q <= cco_pkg::CCO_PTR;
              end
            end
          end
          cco_pkg::CCO_ACK_P, cco_pkg::CCO_ACK_W: begin
            if (scl_fall) begin
              state_q <= cco_pkg::CCO_WDAT;
            end
          end
          cco_pkg::CCO_RD: begin
            if (scl_fall) begin
              if (cnt_q == cco_pkg::I2C_LAST) begin
                cnt_q <= 4'h0;
                state_q <= cco_pkg::CCO_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          cco_pkg::CCO_RACK: begin
            if (scl_rise) begin
              mack_q <= !sda_s;
            end else if (scl_fall) begin
              if (mack_q) begin
                shift_q <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
                state_q <= cco_pkg::CCO_RD;
              end else begin
                state_q <= cco_pkg::CCO_IDLE;
              end
            end
          end
          default: begin
            state_q <= cco_pkg::CCO_IDLE;
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe_out = (state_q == cco_pkg::CCO_ACK_A) ||
                          (state_q == cco_pkg::CCO_ACK_P) ||
                          (state_q == cco_pkg::CCO_ACK_W) ||
                          ((state_q == cco_pkg::CCO_RD) && !shift_q[7]);

  // ----------------------------------------------------------------------
  // comparator path
  // ----------------------------------------------------------------------
  logic cmp_en;
  logic cmp_raw;
  logic comparator_deglitch;
  logic [27:0] deg_limit;
  logic trigger;

  assign cmp_en = opt_q[cco_pkg::BIT_DEG_HI:cco_pkg::BIT_DEG_LO] != cco_pkg::DEG_OFF;
  // high means the output is released
  assign cmp_raw = opt_q[cco_pkg::BIT_POLARITY] ? above_s : !above_s;
  assign trigger = cmp_en && !comparator_deglitch;

  always_comb begin
    case (opt_q[cco_pkg::BIT_DEG_HI:cco_pkg::BIT_DEG_LO])
      cco_pkg::DEG_1US: deg_limit = cco_pkg::DEG_1US_CYC;
      cco_pkg::DEG_2MS: deg_limit = DEG_2MS_CYCLES;
      cco_pkg::DEG_5S: deg_limit = DEG_5S_CYCLES;
      default: deg_limit = cco_pkg::DEG_1US_CYC;
    endcase
  end

  cco_fall_deglitch #(.CW(28)) u_deglitch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .enable_in(cmp_en),
    .raw_in(cmp_raw),
    .limit_in(deg_limit),
    .level_out(comparator_deglitch)
  );

  // ----------------------------------------------------------------------
  // option word, timers and self-clearing bits
  // ----------------------------------------------------------------------
  logic shutoff_q;
  logic [22:0] ship_cnt_q;
  logic ship_done;
  logic [36:0] wake_cnt_q;
  logic wake_timeout_q;
  logic wake_active;
  logic wake_active_q;
  logic wake_done;

  assign ship_done = opt_q[cco_pkg::BIT_SHIP] && (ship_cnt_q == SHIP_CYCLES - 23'h1);
  assign wake_active = opt_q[cco_pkg::BIT_WAKE] && batt_low_s && !wake_timeout_q;
  assign wake_done = wake_active_q && !batt_low_s;

  // a host write to the low byte in the same cycle as a self-clear wins: it is the newer intent
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      opt_q <= cco_pkg::RESET_VALUE;
    end else begin
      if (ship_done) begin
        opt_q[cco_pkg::BIT_SHIP] <= 1'b0;
      end
      if (wake_done) begin
        opt_q[cco_pkg::BIT_WAKE] <= 1'b0;
      end
      if (wr_low) begin
        opt_q[7:0] <= wr_data_q;
      end
      if (wr_high) begin
        opt_q[15:8] <= wr_data_q;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ship_cnt_q <= 23'h00_0000;
    end else if (!opt_q[cco_pkg::BIT_SHIP] || ship_done) begin
      ship_cnt_q <= 23'h00_0000;
    end else begin
      ship_cnt_q <= ship_cnt_q + 23'h1;
    end
  end

  // timeout holds off the charge until the bit is cleared and set again
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_q <= 37'h0;
      wake_timeout_q <= 1'b0;
      wake_active_q <= 1'b0;
    end else begin
      wake_active_q <= wake_active;
      if (!opt_q[cco_pkg::BIT_WAKE]) begin
        wake_cnt_q <= 37'h0;
        wake_timeout_q <= 1'b0;
      end else if (wake_active) begin
        if (wake_cnt_q == WAKE_CYCLES - 37'h1) begin
          wake_timeout_q <= 1'b1;
        end else begin
          wake_cnt_q <= wake_cnt_q + 37'h1;
        end
      end
    end
  end

  // latched until software clears the enable; with the enable clear a trigger does not set it
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      shutoff_q <= 1'b0;
    end else if (opt_q[cco_pkg::BIT_SHUTOFF] && trigger) begin
      shutoff_q <= 1'b1;
    end else if (!opt_q[cco_pkg::BIT_SHUTOFF]) begin
      shutoff_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      batt_current_monitor_out <= 1'b0;
      system_power_monitor_out <= 1'b0;
      processor_hot_alert_lowpower_out <= 1'b0;
      input_resistor_select_out <= 1'b0;
      charge_resistor_select_out <= 1'b0;
      power_monitor_gain_out <= 1'b0;
      high_impedance_mode_out <= 1'b0;
      pass_through_mode_out <= 1'b0;
      comparator_reference_select_out <= 1'b0;
      comparator_output_out <= 1'b1;
      input_high_switch_off_out <= 1'b0;
      output_high_switch_off_out <= 1'b0;
      charger_good_out <= 1'b0;
      shipping_discharge_out <= 1'b0;
      wakeup_charge_out <= 1'b0;
    end else begin
      batt_current_monitor_out <= opt_q[cco_pkg::BIT_BATT_MON] && !low_power_mode_in;
      system_power_monitor_out <= opt_q[cco_pkg::BIT_SYS_PWR] && !low_power_mode_in;
      processor_hot_alert_lowpower_out <=
        opt_q[cco_pkg::BIT_LPHOT_HI:cco_pkg::BIT_LPHOT_LO] == cco_pkg::LPHOT_SYS;
      input_resistor_select_out <= opt_q[cco_pkg::BIT_IN_RES];
      charge_resistor_select_out <= opt_q[cco_pkg::BIT_CHG_RES];
      power_monitor_gain_out <= opt_q[cco_pkg::BIT_GAIN];
      high_impedance_mode_out <= !limit_pin_s && !opt_q[cco_pkg::BIT_PIN_SEL];
      pass_through_mode_out <= opt_q[cco_pkg::BIT_PASS] ||
                               (!limit_pin_s && opt_q[cco_pkg::BIT_PIN_SEL]);
      comparator_reference_select_out <= opt_q[cco_pkg::BIT_REF_SEL];
      comparator_output_out <= comparator_deglitch;
      input_high_switch_off_out <= shutoff_q;
      output_high_switch_off_out <= shutoff_q;
      charger_good_out <= adapter_good_in && !shutoff_q;
      shipping_discharge_out <= opt_q[cco_pkg::BIT_SHIP];
      wakeup_charge_out <= wake_active;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  batt_lpm_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    low_power_mode_in |=> !batt_current_monitor_out)
    else $error("battery monitor buffer on in low power mode");

  sys_pwr_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    ##1 system_power_monitor_out ==
      $past(opt_q[cco_pkg::BIT_SYS_PWR] && !low_power_mode_in))
    else $error("system power monitor does not follow its enable");

  lphot_rsvd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    opt_q[cco_pkg::BIT_LPHOT_HI] |=> !processor_hot_alert_lowpower_out)
    else $error("reserved processor hot code enabled the function");

  pin_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (!limit_pin_s && opt_q[cco_pkg::BIT_PIN_SEL])
      |=> pass_through_mode_out && !high_impedance_mode_out)
    else $error("limit pin low did not select pass-through");

  cmp_rise_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (cmp_en && cmp_raw) |=> comparator_deglitch ##1 comparator_output_out)
    else $error("comparator rising edge was delayed");

  cmp_fall_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $fell(comparator_deglitch) |-> !$past(cmp_raw) && $past(cmp_en))
    else $error("comparator fell without a low input");

  shutoff_good_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (opt_q[cco_pkg::BIT_SHUTOFF] && trigger)
      |=> ##1 input_high_switch_off_out && output_high_switch_off_out && !charger_good_out)
    else $error("forced shutoff did not open switches and drop charger good");

  ship_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (ship_done && !wr_low) |=> !opt_q[cco_pkg::BIT_SHIP])
    else $error("shipping bit not cleared at window end");

  ship_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $rose(opt_q[cco_pkg::BIT_SHIP]) |=> opt_q[cco_pkg::BIT_SHIP] ##1 shipping_discharge_out)
    else $error("shipping discharge ended early");

  wake_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (wake_active_q && !batt_low_s && !wr_low)
      |=> !opt_q[cco_pkg::BIT_WAKE] ##1 !wakeup_charge_out)
    else $error("auto wakeup not ended when battery recovered");

  ack_drive_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (state_q == cco_pkg::CCO_ADDR && scl_fall && cnt_q == cco_pkg::I2C_BITS &&
     shift_q[7:1] == DEV_ADDR && !start_c && !stop_c) |=> i2c_sda_oe_out)
    else $error("address match not acknowledged");

endmodule
`default_nettype wire

// >>> sim/cco_i2c_host.sv
// two-wire host model for the charger option register pair
`timescale 1ns/1ns
`default_nettype none
module cco_i2c_host #(parameter logic [6:0] ADDR = 7'h2a) (
  input wire logic clk_sys_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_low_out
);
  logic r;
  initial {scl_out, sda_low_out} = 2'h2;
  // 8 clocks a phase, twice the least the slave needs
  task pin(input logic c, input logic d);
    repeat (8) @(posedge clk_sys_in);
    scl_out <= c;
    sda_low_out <= !d;
  endtask
  task bx(input logic d, output logic q);
    pin(1'b0, d);
    pin(1'b1, d);
    repeat (4) @(posedge clk_sys_in);
    q = sda_line_in;
    pin(1'b0, d);
  endtask
  task xb(input logic [7:0] b, input logic a, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bx(b[i], q[i]);
    bx(a, r);
  endtask
  task st(input logic [7:0] b, output logic [7:0] q);
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    xb(b, 1'b1, q);
  endtask
  task stp();
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    st({ADDR, 1'b0}, q);
    xb(p, 1'b1, q);
    xb(d, 1'b1, q);
    stp();
  endtask
  task rd(input logic [7:0] p, output logic [7:0] d);
    st({ADDR, 1'b0}, d);
    xb(p, 1'b1, d);
    st({ADDR, 1'b1}, d);
    xb(8'hff, 1'b1, d);
    stp();
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the charger option register pair
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys_in, rst_n_in, lpm, cmp, blow, pin_n, adp;
  logic [15:0] m;
  logic [7:0] d;
  logic [31:0] s;
  int err_count, n_checks, ship_len;
  wire logic scl, hl, so, oe, bm, sp, hot, ir, cr, gn, hz, pt, rf, co, s1, s2, cg, sh, wk;
  wire logic sda = (oe ? so : 1'b1) & !hl;
  wire logic [15:0] outs = {7'h0, bm, sp, hot, ir, cr, gn, hz, pt, rf};
  wire logic [15:0] pwr = {12'h0, co, s1, s2, cg};
  cco_option_one #(.DEG_2MS_CYCLES(28'h14), .DEG_5S_CYCLES(28'h28), .SHIP_CYCLES(23'h1e),
    .WAKE_CYCLES(37'h190)) i_dut (.clk_sys_in, .rst_n_in, .i2c_scl_in(scl), .i2c_sda_in(sda),
    .i2c_sda_out(so), .i2c_sda_oe_out(oe), .low_power_mode_in(lpm), .comparator_input_in(cmp),
    .batt_below_minsys_in(blow), .current_limit_pin_in(pin_n), .adapter_good_in(adp),
    .batt_current_monitor_out(bm), .system_power_monitor_out(sp),
    .processor_hot_alert_lowpower_out(hot), .input_resistor_select_out(ir),
    .charge_resistor_select_out(cr), .power_monitor_gain_out(gn), .high_impedance_mode_out(hz),
    .pass_through_mode_out(pt), .comparator_reference_select_out(rf), .comparator_output_out(co),
    .input_high_switch_off_out(s1), .output_high_switch_off_out(s2), .charger_good_out(cg),
    .shipping_discharge_out(sh), .wakeup_charge_out(wk));
  cco_i2c_host i_host (.clk_sys_in, .sda_line_in(sda), .scl_out(scl), .sda_low_out(hl));
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) if (sh) ship_len++;
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function logic [15:0] dec(input logic [15:0] w);
    return {7'h0, w[15] & !lpm, w[12] & !lpm, w[14:13] == 2'h1, w[11], w[10], w[9],
      !pin_n & !w[8], w[2] | (!pin_n & w[8]), w[7]};
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task rb(input logic [7:0] p, input logic [7:0] e);
    i_host.rd(p, d);
    chk({8'h0, d}, {8'h0, e});
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst_n_in = 1'b0;
    {lpm, cmp, blow, pin_n, adp} = 5'h3;
    m = 16'h0211;
    s = 32'h50f7;
    wt(2);
    rst_n_in <= 1'b1;
    wt(8);
    chk(outs, dec(m));
    rb(8'h30, m[7:0]);
    for (int i = 0; i < 8; i++) begin
      s = xs(s);
      m = {s[15], i[1:0], s[12:8], s[7:4], 1'b0, s[2], 2'h0};
      lpm <= s[16];
      pin_n <= s[17];
      adp <= m[14:13] != 2'h1;
      i_host.wr(8'h31, m[15:8]);
      i_host.wr(8'h30, m[7:0]);
      wt(4);
      chk(outs, dec(m));
      rb(8'h31, m[15:8]);
    end
    adp <= 1'b1;
    ship_len = 0;
    i_host.wr(8'h30, 8'h12);
    wt(60);
    chk(16'(ship_len inside {[29:32]}), 16'h1);
    rb(8'h30, 8'h10);
    i_host.wr(8'h30, 8'h18);
    cmp <= 1'b1;
    wt(45);
    chk(pwr, 16'h9);
    wt(15);
    chk(pwr, 16'h6);
    cmp <= 1'b0;
    wt(5);
    chk(pwr, 16'he);
    blow <= 1'b1;
    i_host.wr(8'h30, 8'h11);
    wt(4);
    chk({15'h0, wk}, 16'h1);
    blow <= 1'b0;
    wt(6);
    chk({15'h0, wk}, 16'h0);
    rb(8'h30, 8'h10);
    blow <= 1'b1;
    i_host.wr(8'h30, 8'h01);
    wt(400);
    chk({15'h0, wk}, 16'h0);
    rb(8'h30, 8'h01);
    blow <= 1'b0;
    for (int k = 2; k < 4; k++) begin
      cmp <= 1'b0;
      i_host.wr(8'h30, {2'h0, k[1:0], 4'h0});
      cmp <= 1'b1;
      wt((k - 1) * 20);
      chk(pwr, 16'h9);
      wt(8);
      chk(pwr, 16'h1);
    end
    stop_test();
  end
  initial begin
    wt(60000);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
